// ==== inc/tci_map.vh ====
// Address map, field codes and status bit positions of the timer coprocessor integration
`ifndef TCI_MAP_VH
`define TCI_MAP_VH
`define TCI_A_CTRL   16'h0000
`define TCI_A_PMUX   16'h0004
`define TCI_A_MASK   16'h0008
`define TCI_A_DIR    16'h000c
`define TCI_A_PINST  16'h0010
`define TCI_A_LOOP   16'h0014
`define TCI_A_FILT0  16'h0018
`define TCI_A_FILT1  16'h001c
`define TCI_A_STAT   16'h0020
`define TCI_A_XEN    16'h0024
`define TCI_A_MPULO  16'h0028
`define TCI_A_MPUHI  16'h002c
`define TCI_DCP_HI   9'h002
`define TCI_RAM_HI   5'h02
`define TCI_NPIN     5'h13
`define TCI_PMUX_ENC 2'h2
`define TCI_OP_CNT   5'h00
`define TCI_OP_ECMP  5'h01
`define TCI_OP_WCAP  5'h02
`define TCI_OP_NUM   5'h1e
`define TCI_M_ONE    2'h0
`define TCI_M_SWAP   2'h2
`define TCI_INC_W32  2'h1
`define TCI_INC_W64  2'h2
`define TCI_ST_PAR   0
`define TCI_ST_ILL   1
`define TCI_ST_DCP   2
`define TCI_ST_MPU   3
`define TCI_ST_DIS   4
`endif

// ==== rtl/tci_timer_coprocessor.v ====
// Timer coprocessor integration: pins, output disable, timer RAM, engine and transfer unit
`default_nettype none
`include "tci_map.vh"

// One timer RAM bank, 32 words, one write port and one read port
module tci_ram_bank (
  input  wire        clk,
  input  wire [2:0]  we,
  input  wire [4:0]  wa,
  input  wire [98:0] wd,
  input  wire [4:0]  ra,
  output reg  [98:0] rd
);
  reg [98:0] mem [0:31];
  // Field enables let one 33-bit field (data and parity) change alone; read and write may hit different words
  always @(posedge clk) begin
    if (we[0]) mem[wa][32:0] <= wd[32:0];
    if (we[1]) mem[wa][65:33] <= wd[65:33];
    if (we[2]) mem[wa][98:66] <= wd[98:66];
    rd <= mem[ra];
  end
endmodule

// Per-pin suppression filter: a change must persist sel*4+1 cycles to pass
module tci_pin_filter (
  input  wire       clk,
  input  wire       nrst,
  input  wire       raw,
  input  wire [1:0] sel,
  output wire       flt
);
  reg       flt_q;
  reg [3:0] cnt_q;
  assign flt = flt_q;
  // Any return to the held level restarts the count, so short pulses die here
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (raw == flt_q) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= {sel, 2'b00}) begin
      flt_q <= raw;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

module tci_timer_coprocessor (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        hsel,
  input  wire [15:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire [18:0] pinIn,
  output wire [18:0] pinOut,
  output wire [18:0] pinOe,
  input  wire        ch31PadIn,
  output wire        ch31PadOut,
  output wire        ch31PadOe,
  input  wire        gpioPortAPin5,
  input  wire        encoderPhaseError,
  output wire        outputDisableN,
  output wire        clockComparatorOneClk,
  output wire [7:0]  transferRequestLine,
  output wire        mstReq,
  output wire        mstWrite,
  output wire        mstSize64,
  output wire [31:0] mstAddr,
  output wire [63:0] mstWdata,
  input  wire [63:0] mstRdata,
  input  wire        mstAck
);
  localparam X_IDLE = 5'b00001;
  localparam X_RDT  = 5'b00010;
  localparam X_MEM  = 5'b00100;
  localparam X_WRT  = 5'b01000;
  localparam X_UPD  = 5'b10000;
  integer i;
  integer j;
  reg        dp_q, dpRam_q, dpWr_q, rdIss_q, rdDone_q, ph_q, run_q, ch31Int_q, encS1_q, encS2_q;
  reg        xRdV_q, mstWr_q, mstSz_q;
  reg [15:0] apA_q, stat_q;
  reg [31:0] hrdata_q, mask_q, dir_q, mpuLo_q, mpuHi_q, regRd, chOut_q, mstAddr_q;
  reg [1:0]  pmux_q;
  reg [18:0] loop_q, edgeLat_q, fltPrev_q;
  reg [37:0] filt_q;
  reg [7:0]  xen_q, pend_q, curB_q, engReq;
  reg [6:0]  pc_q, hrCnt_q, ra, wa;
  reg [6:0]  stamp_q [0:18];
  reg [24:0] lastCnt_q;
  reg [4:0]  xSt_q;
  reg [2:0]  xc_q, s, we;
  reg [63:0] xBuf_q;
  reg [98:0] wd;
  reg [31:0] engData;
  reg        engWe;
  reg [32:0] cfg_q [0:7];
  reg [32:0] bufA_q [0:7];
  reg [32:0] bufB_q [0:7];
  reg [31:0] curMem_q [0:7];
  reg [11:0] curTmr_q [0:7];
  reg [11:0] rem_q [0:7];
  reg [1:0]  rdBank_q;
  wire [395:0] bankRd;
  wire [18:0]  flt;
  wire [98:0]  rdWord = bankRd[rdBank_q*99 +: 99];

  // Bus decode; RAM field 3 is a hole and reads zero
  wire take   = hsel & htrans[1] & hready;
  wire aRam   = haddr[15:11] == `TCI_RAM_HI && haddr[3:2] != 2'h3;
  wire aDcp   = haddr[15:7] == `TCI_DCP_HI;
  wire cpuWr  = dp_q & dpRam_q & dpWr_q & ~ph_q;
  wire cpuRd  = dp_q & dpRam_q & ~dpWr_q & ~rdIss_q;
  wire regWr  = dp_q & ~dpRam_q & dpWr_q;
  assign hreadyout = ~dp_q | ~dpRam_q | cpuWr | rdDone_q;
  assign hresp  = 1'b0;
  assign hrdata = hrdata_q;

  // Output disable path; source is the received GPIO level or the synced encoder flag
  assign outputDisableN = (pmux_q == `TCI_PMUX_ENC) ? encS2_q : gpioPortAPin5;
  wire disAct = ~outputDisableN;
  assign pinOut = chOut_q[18:0];
  assign pinOe  = dir_q[18:0] & ~({19{disAct}} & mask_q[18:0]);
  assign ch31PadOut = chOut_q[31];
  assign ch31PadOe  = ~ch31Int_q & dir_q[31] & ~(disAct & mask_q[31]);
  // Internal-only channel feeds the comparator ahead of the pad buffer
  assign clockComparatorOneClk = ch31Int_q ? chOut_q[31] : ch31PadIn;

  // Instruction fields of the word the engine fetched last phase
  wire [4:0]  op  = rdWord[4:0];
  wire [4:0]  ch  = rdWord[9:5];
  wire [2:0]  rl  = rdWord[12:10];
  wire [24:0] cmp = rdWord[57:33];
  wire [31:0] dat = rdWord[97:66];
  wire exe   = run_q & ph_q;
  wire chPin = ch < `TCI_NPIN;
  wire wcap  = exe && op == `TCI_OP_WCAP && chPin;
  wire [18:0] wcapClr = wcap ? (19'h1 << ch) : 19'h0;
  wire [18:0] rise = flt & ~fltPrev_q;

  // Pin filters with loopback from the channel outputs
  genvar g;
  generate
    for (g = 0; g < 19; g = g + 1) begin : gPin
      tci_pin_filter uFlt (
        .clk (ref_clk),
        .nrst(nrst),
        .raw (loop_q[g] ? chOut_q[g] : pinIn[g]),
        .sel (filt_q[2*g +: 2]),
        .flt (flt[g])
      );
    end
    for (g = 0; g < 4; g = g + 1) begin : gBank
      tci_ram_bank uBank (
        .clk(ref_clk),
        .we (wa[1:0] == g ? we : 3'h0),
        .wa (wa[6:2]),
        .wd (wd),
        .ra (ra[6:2]),
        .rd (bankRd[g*99 +: 99])
      );
    end
  endgenerate

  // Engine step: counters wrap at the compare value, captures take stamp and count
  always @* begin
    engWe   = 1'b0;
    engData = dat;
    engReq  = 8'h0;
    if (exe && op == `TCI_OP_CNT) begin
      engWe = 1'b1;
      if (dat[24:0] >= cmp) begin
        engData = 32'h0;
        engReq[rl] = rdWord[13];
      end else begin
        engData = {7'h0, dat[24:0] + 25'h1};
      end
    end else if (wcap && edgeLat_q[ch]) begin
      engWe   = 1'b1;
      engData = {stamp_q[ch], lastCnt_q};
      engReq[rl] = rdWord[13];
    end
  end

  // Transfer packet chosen next: lowest pending number wins
  always @* begin
    s = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (pend_q[i]) s = i[2:0];
    end
  end
  wire [32:0] cfgS = cfg_q[s];
  wire [32:0] cfgC = cfg_q[xc_q];
  wire [11:0] tmrC = curTmr_q[xc_q];
  wire anyP    = |pend_q;
  wire dcpBad  = ^cfgS | ^bufA_q[s] | ^bufB_q[s];
  wire mpuBad  = curMem_q[s] < mpuLo_q || curMem_q[s] > mpuHi_q;
  wire [7:0] svc = (xSt_q == X_IDLE && anyP) ? (8'h1 << s) : 8'h0;
  wire [7:0] req = engReq & xen_q;
  wire [7:0] lost = req & pend_q & ~svc;
  wire last = rem_q[xc_q] <= 12'h1;
  wire xWrGo = ~ph_q & ~cpuWr & (xSt_q == X_WRT);
  assign transferRequestLine = engReq;
  assign mstReq    = xSt_q == X_MEM;
  assign mstWrite  = mstWr_q;
  assign mstSize64 = mstSz_q;
  assign mstAddr   = mstAddr_q;
  assign mstWdata  = xBuf_q;

  // Read port: engine fetch in phase 0, bus then transfer unit in phase 1
  always @* begin
    if (!ph_q) ra = pc_q;
    else if (cpuRd) ra = apA_q[10:4];
    else ra = tmrC[10:4];
  end

  // Write port: bus then transfer unit in phase 0, engine write-back in phase 1
  always @* begin
    wa = pc_q;
    we = 3'h0;
    wd = {^engData, engData, 66'h0};
    if (!ph_q) begin
      if (cpuWr) begin
        wa = apA_q[10:4];
        we = 3'h1 << apA_q[3:2];
        wd = {3{^hwdata, hwdata}};
      end else if (xWrGo) begin
        wa = tmrC[10:4];
        we = mstSz_q ? 3'h6 : 3'h4;
        wd = {^xBuf_q[31:0], xBuf_q[31:0], ^xBuf_q[63:32], xBuf_q[63:32], 33'h0};
      end
    end else if (engWe) begin
      we = 3'h4;
    end
  end

  // Register read value, sampled at the address phase
  always @* begin
    regRd = 32'h0;
    if (aDcp) begin
      if (haddr[3:2] == 2'h0) regRd = cfg_q[haddr[6:4]][31:0];
      else if (haddr[3:2] == 2'h1) regRd = bufA_q[haddr[6:4]][31:0];
      else if (haddr[3:2] == 2'h2) regRd = bufB_q[haddr[6:4]][31:0];
      else regRd = {curB_q[haddr[6:4]], 7'h0, rem_q[haddr[6:4]], curTmr_q[haddr[6:4]]};
    end
    else if (haddr == `TCI_A_CTRL) regRd = {30'h0, ch31Int_q, run_q};
    else if (haddr == `TCI_A_PMUX) regRd = {30'h0, pmux_q};
    else if (haddr == `TCI_A_MASK) regRd = mask_q;
    else if (haddr == `TCI_A_DIR) regRd = dir_q;
    else if (haddr == `TCI_A_PINST) regRd = {13'h0, pinIn};
    else if (haddr == `TCI_A_LOOP) regRd = {13'h0, loop_q};
    else if (haddr == `TCI_A_FILT0) regRd = filt_q[31:0];
    else if (haddr == `TCI_A_FILT1) regRd = {26'h0, filt_q[37:32]};
    else if (haddr == `TCI_A_STAT) regRd = {16'h0, stat_q[15:5], disAct, stat_q[3:0]};
    else if (haddr == `TCI_A_XEN) regRd = {24'h0, xen_q};
    else if (haddr == `TCI_A_MPULO) regRd = mpuLo_q;
    else if (haddr == `TCI_A_MPUHI) regRd = mpuHi_q;
  end

  // Bus slave, control registers, engine, sticky status
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dp_q <= 1'b0; dpRam_q <= 1'b0; dpWr_q <= 1'b0; rdIss_q <= 1'b0; rdDone_q <= 1'b0;
      apA_q <= 16'h0; hrdata_q <= 32'h0; run_q <= 1'b0; ch31Int_q <= 1'b0; pmux_q <= 2'h0;
      mask_q <= 32'h0; dir_q <= 32'h0; loop_q <= 19'h0; filt_q <= 38'h0; stat_q <= 16'h0;
      mpuLo_q <= 32'h0; mpuHi_q <= 32'h0; ph_q <= 1'b0; pc_q <= 7'h0; hrCnt_q <= 7'h0;
      lastCnt_q <= 25'h0; chOut_q <= 32'h0; edgeLat_q <= 19'h0; fltPrev_q <= 19'h0;
      encS1_q <= 1'b1; encS2_q <= 1'b1; rdBank_q <= 2'h0;
    end else begin
      if (dp_q && hreadyout) dp_q <= 1'b0;
      if (take) begin
        dp_q <= 1'b1; dpRam_q <= aRam; dpWr_q <= hwrite; apA_q <= haddr;
        if (!hwrite && !aRam) hrdata_q <= regRd;
      end
      // RAM read: issue in a free phase, load data, then complete
      if (ph_q && cpuRd) rdIss_q <= 1'b1;
      if (rdIss_q && !rdDone_q) begin
        rdDone_q <= 1'b1;
        hrdata_q <= apA_q[3:2] == 2'h0 ? rdWord[31:0] : apA_q[3:2] == 2'h1 ? rdWord[64:33] : rdWord[97:66];
      end
      if (rdDone_q) begin
        rdIss_q <= 1'b0;
        rdDone_q <= 1'b0;
      end
      if (regWr) begin
        if (apA_q == `TCI_A_CTRL) {ch31Int_q, run_q} <= hwdata[1:0];
        else if (apA_q == `TCI_A_PMUX) pmux_q <= hwdata[1:0];
        else if (apA_q == `TCI_A_MASK) mask_q <= hwdata;
        else if (apA_q == `TCI_A_DIR) dir_q <= hwdata;
        else if (apA_q == `TCI_A_LOOP) loop_q <= hwdata[18:0];
        else if (apA_q == `TCI_A_FILT0) filt_q[31:0] <= hwdata;
        else if (apA_q == `TCI_A_FILT1) filt_q[37:32] <= hwdata[5:0];
        else if (apA_q == `TCI_A_MPULO) mpuLo_q <= hwdata;
        else if (apA_q == `TCI_A_MPUHI) mpuHi_q <= hwdata;
      end
      // Status: write one to clear, a same-cycle event still sets
      stat_q <= (stat_q & ~((regWr && apA_q == `TCI_A_STAT) ? hwdata[15:0] : 16'h0)) | {lost,
        4'h0, (xSt_q == X_IDLE && anyP && !dcpBad && mpuBad), (xSt_q == X_IDLE && anyP && dcpBad),
        (exe && op >= `TCI_OP_NUM), (exe && (rdWord[32] != ^rdWord[31:0]))};
      // Encoder error inverted and double-flopped
      encS1_q <= ~encoderPhaseError;
      encS2_q <= encS1_q;
      ph_q <= ~ph_q;
      rdBank_q <= ra[1:0];
      hrCnt_q <= (exe && pc_q == 7'h7f) ? 7'h0 : hrCnt_q + 7'h1;
      if (exe) begin
        pc_q <= pc_q + 7'h1;
        if (op == `TCI_OP_CNT) lastCnt_q <= engData[24:0];
        if (op == `TCI_OP_ECMP) chOut_q[ch] <= lastCnt_q < cmp;
      end
      if (!run_q) pc_q <= 7'h0;
      fltPrev_q <= flt;
      edgeLat_q <= (edgeLat_q & ~wcapClr) | rise;
    end
  end

  // Edge stamps of the hardware count, one per pin
  always @(posedge ref_clk) begin
    for (j = 0; j < 19; j = j + 1) begin
      if (rise[j]) stamp_q[j] <= hrCnt_q;
    end
  end

  // Transfer unit sequencer, enables and pending requests
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xSt_q <= X_IDLE; xc_q <= 3'h0; xen_q <= 8'h0; pend_q <= 8'h0; xRdV_q <= 1'b0;
      mstWr_q <= 1'b0; mstSz_q <= 1'b0; mstAddr_q <= 32'h0; xBuf_q <= 64'h0;
    end else begin
      pend_q <= (pend_q & ~svc) | req;
      xRdV_q <= ph_q & ~cpuRd & (xSt_q == X_RDT) & ~xRdV_q;
      case (xSt_q)
        X_IDLE: begin
          if (anyP) begin
            xc_q <= s;
            if (mpuBad && !dcpBad) xen_q[s] <= 1'b0;
            if (!dcpBad && !mpuBad) begin
              mstAddr_q <= curMem_q[s];
              mstWr_q <= ~cfgS[2];
              mstSz_q <= cfgS[3];
              xSt_q <= cfgS[2] ? X_MEM : X_RDT;
            end
          end
        end
        X_RDT: if (xRdV_q) begin
          xBuf_q <= mstSz_q ? {rdWord[64:33], rdWord[97:66]} : {32'h0, rdWord[97:66]};
          xSt_q <= X_MEM;
        end
        X_MEM: if (mstAck) begin
          if (!mstWr_q) xBuf_q <= mstRdata;
          xSt_q <= mstWr_q ? X_UPD : X_WRT;
        end
        X_WRT: if (xWrGo) xSt_q <= X_UPD;
        X_UPD: begin
          if (last && cfgC[1:0] == `TCI_M_ONE) xen_q[xc_q] <= 1'b0;
          xSt_q <= X_IDLE;
        end
        default: xSt_q <= X_IDLE;
      endcase
      if (regWr && apA_q == `TCI_A_XEN) xen_q <= hwdata[7:0];
    end
  end

  // Packet store with parity and the running addresses of each packet
  always @(posedge ref_clk) begin
    if (regWr && apA_q[15:7] == `TCI_DCP_HI) begin
      if (apA_q[3:2] == 2'h0) begin
        cfg_q[apA_q[6:4]] <= {^hwdata, hwdata};
        curMem_q[apA_q[6:4]] <= bufA_q[apA_q[6:4]][31:0];
        curTmr_q[apA_q[6:4]] <= hwdata[19:8];
        rem_q[apA_q[6:4]] <= hwdata[31:20];
        curB_q[apA_q[6:4]] <= 1'b0;
      end
      else if (apA_q[3:2] == 2'h1) bufA_q[apA_q[6:4]] <= {^hwdata, hwdata};
      else if (apA_q[3:2] == 2'h2) bufB_q[apA_q[6:4]] <= {^hwdata, hwdata};
    end else if (xSt_q == X_UPD) begin
      curTmr_q[xc_q] <= tmrC + (cfgC[4] ? 12'h10 : 12'h8);
      curMem_q[xc_q] <= curMem_q[xc_q] + (cfgC[6:5] == `TCI_INC_W32 ? 32'h4 :
        cfgC[6:5] == `TCI_INC_W64 ? 32'h8 : 32'h0);
      rem_q[xc_q] <= rem_q[xc_q] - 12'h1;
      if (last) begin
        rem_q[xc_q] <= cfgC[31:20];
        curTmr_q[xc_q] <= cfgC[19:8];
        if (cfgC[1:0] == `TCI_M_SWAP) begin
          curB_q[xc_q] <= ~curB_q[xc_q];
          curMem_q[xc_q] <= curB_q[xc_q] ? bufA_q[xc_q][31:0] : bufB_q[xc_q][31:0];
        end else begin
          curMem_q[xc_q] <= curB_q[xc_q] ? bufB_q[xc_q][31:0] : bufA_q[xc_q][31:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/tci_monitor.sv ====
// Port-level assertion checker for the timer coprocessor integration
`default_nettype none
`include "tci_map.vh"
module tci_monitor (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [18:0] pinOe,
  input wire logic        gpioPortAPin5,
  input wire logic        encoderPhaseError,
  input wire logic        outputDisableN,
  input wire logic        ch31PadIn,
  input wire logic        ch31PadOe,
  input wire logic        clockComparatorOneClk,
  input wire logic        mstReq,
  input wire logic        mstAck,
  input wire logic        mstSize64,
  input wire logic [31:0] mstAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wAddr_q;
  logic        wPend_q;
  logic [31:0] dir_q;
  logic [31:0] mask_q;
  logic [1:0]  ctrl_q;
  logic [1:0]  pmux_q;
  logic [1:0]  up_q;
  // Shadow registers from completed writes; up_q masks synchroniser values from reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wPend_q <= 1'h0;
      wAddr_q <= 16'h0;
      dir_q <= 32'h0;
      mask_q <= 32'h0;
      ctrl_q <= 2'h0;
      pmux_q <= 2'h0;
      up_q <= 2'h0;
    end else begin
      up_q <= up_q + {1'h0, up_q != 2'h2};
      if (hreadyout) begin
        wPend_q <= hsel && htrans[1] && hwrite;
        wAddr_q <= haddr;
      end
      if (wPend_q && hreadyout) begin
        case (wAddr_q)
          `TCI_A_DIR: dir_q <= hwdata;
          `TCI_A_MASK: mask_q <= hwdata;
          `TCI_A_CTRL: ctrl_q <= hwdata[1:0];
          `TCI_A_PMUX: pmux_q <= hwdata[1:0];
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  bus_okay_a: assert property (hresp == 1'h0) else $error("error response");
  reg_nowait_a: assert property (hsel && htrans[1] && hreadyout && haddr <= `TCI_A_MPUHI |=> hreadyout)
    else $error("register access stalled");
  ram_wait_a: assert property ($fell(hreadyout) |-> ##[1:4] hreadyout) else $error("stall too long");
  mask_off_a: assert property (!outputDisableN |-> pinOe == (dir_q[18:0] & ~mask_q[18:0]))
    else $error("masked pin still driven");
  drive_back_a: assert property (outputDisableN |-> pinOe == dir_q[18:0])
    else $error("enable wrong while not disabled");
  gpio_src_a: assert property (pmux_q != `TCI_PMUX_ENC |-> outputDisableN == gpioPortAPin5)
    else $error("disable not from gpio");
  enc_sync_a: assert property (pmux_q == `TCI_PMUX_ENC && up_q == 2'h2
    |-> outputDisableN == !$past(encoderPhaseError, 2)) else $error("encoder path not two stages");
  pad_tap_a: assert property (!ctrl_q[1] |-> clockComparatorOneClk == ch31PadIn)
    else $error("comparator clock not pad level");
  int_only_a: assert property (ctrl_q[1] |-> !ch31PadOe) else $error("internal channel drives pad");
  mst_hold_a: assert property (mstReq && !mstAck |=> mstReq && $stable(mstAddr) && $stable(mstSize64))
    else $error("master request dropped or changed");
  cover property (!outputDisableN && mask_q[18:0] != 19'h0);
  cover property ($fell(hreadyout));
  cover property (mstReq && mstAck);
  cover property (ctrl_q[1] && ch31PadIn);
endmodule
bind tci_timer_coprocessor tci_monitor u_mon (
  .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .pinOe(pinOe), .gpioPortAPin5(gpioPortAPin5),
  .encoderPhaseError(encoderPhaseError), .outputDisableN(outputDisableN), .ch31PadIn(ch31PadIn),
  .ch31PadOe(ch31PadOe), .clockComparatorOneClk(clockComparatorOneClk), .mstReq(mstReq),
  .mstAck(mstAck), .mstSize64(mstSize64), .mstAddr(mstAddr)
);
`default_nettype wire

// ==== dv/tci_mem_model.sv ====
// System memory partner of the transfer unit master port, answer delay set by the bench
`default_nettype none
module tci_mem_model (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        mstReq,
  input wire logic [31:0] mstAddr,
  input wire logic [3:0]  ackDelay,
  output var logic [63:0] mstRdata,
  output var logic        mstAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  // Read data is valid only with the ack; otherwise it churns so stale data cannot pass
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 4'h0;
      mstAck <= 1'h0;
      mstRdata <= 64'h0;
    end else if (mstReq && !mstAck && wait_q >= ackDelay) begin
      wait_q <= 4'h0;
      mstAck <= 1'h1;
      mstRdata <= {mstAddr, ~mstAddr};
    end else begin
      wait_q <= (mstReq && !mstAck) ? wait_q + 4'h1 : 4'h0;
      mstAck <= 1'h0;
      mstRdata <= ~mstRdata;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tci_timer_coprocessor_tb.sv ====
// Self-checking testbench of the timer coprocessor integration
`default_nettype none
`include "tci_map.vh"
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, a, e); end end
module tci_timer_coprocessor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'h0;
  logic        nrst = 1'h0;
  logic        hsel = 1'h0;
  logic [15:0] haddr = 16'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [18:0] pinIn = 19'h0;
  logic        ch31PadIn = 1'h0;
  logic        gpioPortAPin5 = 1'h0;
  logic        encoderPhaseError = 1'h0;
  logic [3:0]  ackDelay = 4'h0;
  wire logic [31:0] hrdata, mstAddr;
  wire logic [18:0] pinOe;
  wire logic [63:0] mstRdata;
  wire logic [7:0]  transferRequestLine;
  wire logic hreadyout, hresp, ch31PadOe, outputDisableN, clockComparatorOneClk;
  wire logic mstReq, mstWrite, mstSize64, mstAck;
  logic [31:0] rdv, dirV, maskV, bufA;
  logic [31:0] ram [0:11];
  logic [19:0] e;
  int          mismatches = 0;
  int          numChecks = 0;
  int          i;
  int          wl [0:3] = '{0, 31, 32, 127};

  always #20 ref_clk = ~ref_clk;

  tci_timer_coprocessor u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pinIn(pinIn), .pinOut(), .pinOe(pinOe), .ch31PadIn(ch31PadIn), .ch31PadOut(),
    .ch31PadOe(ch31PadOe), .gpioPortAPin5(gpioPortAPin5), .encoderPhaseError(encoderPhaseError),
    .outputDisableN(outputDisableN), .clockComparatorOneClk(clockComparatorOneClk),
    .transferRequestLine(transferRequestLine), .mstReq(mstReq), .mstWrite(mstWrite),
    .mstSize64(mstSize64), .mstAddr(mstAddr), .mstWdata(), .mstRdata(mstRdata), .mstAck(mstAck)
  );
  tci_mem_model u_mem (
    .ref_clk(ref_clk), .nrst(nrst), .mstReq(mstReq), .mstAddr(mstAddr), .ackDelay(ackDelay),
    .mstRdata(mstRdata), .mstAck(mstAck)
  );

  task automatic testDone;
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic sig(input int k);
    logic [3:0] s;
    s = {mstAck, mstReq, transferRequestLine[0], hreadyout};
    return s[k];
  endfunction
  // Bounded wait on a handshake; running out ends the run as a failure
  task automatic waitFor(input int k, input logic v);
    int n;
    n = 0;
    while (sig(k) !== v) begin
      n++;
      if (n > 400) begin
        mismatches++;
        $display("BAD %0t wait %0d timed out", $time, k);
        testDone();
      end
      @(posedge ref_clk);
    end
  endtask
  // One single AHB transfer; address phase held until hready, read data taken at the last edge
  task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge ref_clk);
    waitFor(0, 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    waitFor(0, 1'h1);
    rdv = hrdata;
  endtask
  function automatic logic [15:0] ramAddr(input int w, input int f);
    return 16'(32'h1000 + w * 16 + f * 4);
  endfunction
  // Expected {disable level, pin enables} for a source code and both source levels
  function automatic logic [19:0] expDis(input logic [1:0] pm, input logic g, input logic en);
    logic dn;
    dn = (pm == `TCI_PMUX_ENC) ? !en : g;
    return {dn, dirV[18:0] & ~(dn ? 19'h0 : maskV[18:0])};
  endfunction

  initial begin
    void'($urandom(32'h51b3ed38));
    repeat (5) @(posedge ref_clk);
    `CHK({hreadyout, hresp, pinOe, mstReq, hrdata}, 54'h200000_00000000)
    nrst <= 1'h1;
    @(posedge ref_clk);
    dirV = $urandom;
    maskV = $urandom | 32'h80000000;
    ahb(1'h1, `TCI_A_DIR, dirV);
    ahb(1'h1, `TCI_A_MASK, maskV);
    ahb(1'h0, `TCI_A_MASK, 32'h0);
    `CHK(rdv, maskV)
    ahb(1'h1, 16'h0030, 32'hffffffff);
    ahb(1'h0, 16'h0030, 32'h0);
    `CHK(rdv, 32'h0)
    // Every source code with random levels; the synchroniser needs two edges
    for (i = 0; i < 8; i++) begin
      ahb(1'h1, `TCI_A_PMUX, i / 2);
      gpioPortAPin5 <= 1'($urandom);
      encoderPhaseError <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      e = expDis(i[2:1], gpioPortAPin5, encoderPhaseError);
      `CHK({outputDisableN, pinOe}, e)
      ahb(1'h0, `TCI_A_STAT, 32'h0);
      `CHK(rdv[`TCI_ST_DIS], !e[19])
    end
    ahb(1'h1, `TCI_A_PMUX, 32'h0);
    gpioPortAPin5 <= 1'h1;
    pinIn <= 19'($urandom);
    repeat (4) @(posedge ref_clk);
    ahb(1'h0, `TCI_A_PINST, 32'h0);
    `CHK(rdv[18:0] & ~dirV[18:0], pinIn & ~dirV[18:0])
    for (i = 0; i < 2; i++) begin
      ch31PadIn <= i[0];
      repeat (2) @(posedge ref_clk);
      `CHK(clockComparatorOneClk, i[0])
    end
    ahb(1'h1, `TCI_A_CTRL, 32'h2);
    @(posedge ref_clk);
    `CHK({ch31PadOe, clockComparatorOneClk}, 2'h0)
    ahb(1'h1, `TCI_A_CTRL, 32'h0);
    // Words 0, 31, 32 and 127 (banks 0 and 3), every field, written back to back then read back
    for (i = 0; i < 12; i++) begin
      ram[i] = $urandom;
      ahb(1'h1, ramAddr(wl[i / 3], i % 3), ram[i]);
    end
    for (i = 0; i < 12; i++) begin
      ahb(1'h0, ramAddr(wl[i / 3], i % 3), 32'h0);
      `CHK(rdv, ram[i])
    end
    ahb(1'h0, ramAddr(0, 3), 32'h0);
    `CHK(rdv, 32'h0)
    // Program: word 0 counts and raises request line 0, word 5 holds an illegal code
    for (i = 0; i < 128; i++) begin
      ahb(1'h1, ramAddr(i, 0), (i == 0) ? 32'h2000 : (i == 5) ? {27'h0, `TCI_OP_NUM} : 32'h0);
      ahb(1'h1, ramAddr(i, 1), 32'h0);
      ahb(1'h1, ramAddr(i, 2), 32'h0);
    end
    bufA = {16'h2000, 13'($urandom), 3'h0};
    ahb(1'h1, `TCI_A_MPULO, bufA);
    ahb(1'h1, `TCI_A_MPUHI, bufA + 32'hff);
    ahb(1'h1, 16'h0104, bufA);
    ahb(1'h1, 16'h0108, bufA + 32'h80);
    ahb(1'h1, 16'h0100, 32'h0020404d);
    ahb(1'h1, `TCI_A_XEN, 32'h1);
    ahb(1'h1, `TCI_A_CTRL, 32'h1);
    waitFor(1, 1'h1);
    `CHK(transferRequestLine, 8'h1)
    for (i = 0; i < 2; i++) begin
      ackDelay <= 4'($urandom % 4);
      waitFor(2, 1'h1);
      `CHK({mstWrite, mstSize64, mstAddr}, {2'h1, bufA + 32'(i * 8)})
      waitFor(3, 1'h1);
      @(posedge ref_clk);
    end
    ahb(1'h0, `TCI_A_STAT, 32'h0);
    `CHK(rdv[3:0], 4'h2)
    // Empty protection window: the reloaded packet must be stopped and flagged
    ahb(1'h1, `TCI_A_STAT, 32'hffff);
    ahb(1'h1, `TCI_A_MPULO, bufA + 32'h100);
    ahb(1'h1, 16'h0100, 32'h0020404d);
    repeat (300) @(posedge ref_clk);
    ahb(1'h0, `TCI_A_STAT, 32'h0);
    `CHK(rdv[`TCI_ST_MPU], 1'h1)
    testDone();
  end
endmodule
`default_nettype wire
